// File: mmd_pkg.sv
// Package for the memory map decoder: register map, fields, reset values and decode types.
`default_nettype none
package mmd_pkg;
    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [7:0] RAM_POS_IDX   = 8'h10;
    localparam logic [7:0] REG_POS_IDX   = 8'h11;
    localparam logic [7:0] EE_POS_IDX    = 8'h12;
    localparam logic [7:0] MISC_IDX      = 8'h13;
    localparam logic [7:0] PAGE_IDX      = 8'h30;
    localparam logic [7:0] PORTK_DAT_IDX = 8'h3c;
    localparam logic [7:0] PORTK_DIR_IDX = 8'h3d;

    localparam logic [7:0] RAM_POS_RST = 8'h20;
    localparam logic [7:0] REG_POS_RST = 8'h00;
    localparam logic [7:0] EE_POS_RST  = 8'h01;

    // Field positions inside the mapping registers.
    localparam int RAM_POS_LSB = 5;
    localparam int REG_POS_LSB = 3;
    localparam int EE_POS_LSB  = 4;
    localparam int EE_EN_BIT   = 0;
    localparam int MSW_BIT     = 0;
    localparam int TEST_BIT    = 0;

    // Region masks and placement inside the 64K space.
    localparam logic [15:0] REG_MASK      = 16'hfc00;
    localparam logic [15:0] RAM_MASK      = 16'he000;
    localparam logic [15:0] EE_MASK       = 16'hf800;
    localparam logic [15:0] EE_UPPER_HALF = 16'h0800;
    localparam logic [15:0] RAM_HALF_LAST = 16'h0fff;
    localparam logic [15:0] RAM_OFS_MASK  = 16'h1fff;
    localparam logic [15:0] FREG_BASE     = 16'h00f4;
    localparam logic [15:0] FREG_MASK     = 16'h03fc;
    localparam logic [15:0] DBG_BASE      = 16'hff00;
    localparam logic [15:0] DBG_MASK      = 16'hff00;
    localparam logic [15:0] FIX6_BASE     = 16'h4000;
    localparam logic [15:0] WIN_BASE      = 16'h8000;
    localparam logic [15:0] FIX7_BASE     = 16'hc000;
    localparam logic [15:0] W16_MASK      = 16'hc000;
    localparam logic [15:0] W32_MASK      = 16'h8000;
    localparam logic [2:0]  PAGE_FIX6     = 3'h6;
    localparam logic [2:0]  PAGE_FIX7     = 3'h7;

    // Port K pin positions.
    localparam int PK_ECS = 4;
    localparam int PK_GP  = 3;

    typedef enum logic [2:0] {
        MMD_NONE, MMD_DEBUG, MMD_REGS, MMD_FLASH_REG,
        MMD_RAM, MMD_EEPROM, MMD_FLASH, MMD_EXTERNAL
    } mmd_target_type;

    typedef struct packed {
        mmd_target_type target;
        logic [1:0]     array_sel;
        logic [16:0]    offset;
        logic           in_window;
    } mmd_decode_type;

    typedef struct packed {
        logic [7:0] ram_pos;
        logic [7:0] reg_pos;
        logic [7:0] ee_pos;
    } mmd_map_type;
endpackage
`default_nettype wire

// File: mmd_decoder.sv
// Memory map decoder: mapping registers, precedence decode, paging and port K emulation pins.
//
// Functional notes
// - Normal modes: only first write to each position field is accepted.
// - A mapping write alters decode one cycle after it.
// - Register block wins over overlapped RAM or EEPROM addresses.
// - Precedence: debug ROM, registers, RAM, EEPROM, flash, external.
// - Active debug ROM overrides all other resources.
// - Top array fixed at 4000-7FFF, and at C000-FFFF unless the test window is on; all arrays via window.
// - 1K register block at zero after reset, lower 1K of 2K boundary.
// - Register position bits 15:11 give upper five decode address bits.
// - Position fields write once in normal, anytime in special, always readable.
// - Stop-in-wait bit shuts mapping in wait; writable only in normal modes.
// - Word access straddling the two 4K RAM arrays takes two cycles.
// - RAM at 2000 after reset, relocatable to 8K boundary by bits 15:13.
// - EEPROM at 0800 after reset, upper 2K of 4K boundary by 15:12.
// - EEPROM enable removes or maps EEPROM; forced one in single-chip modes.
// - Three-bit page index picks one of eight 16K pages in window.
// - Four-byte flash register window shows array chosen by page index.
// - 32K test window exists only in special mode and replaces user window.
// - Emulation drives page index and chip select pins; otherwise general I/O.
// - Special mode when mode select special bit is zero, normal when one.
// - Test window at 8000-FFFF only in special mode with test bit set.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder #(
    parameter int ADDR_W = 8
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  mode_select_special_n,
    input  wire logic                  single_chip,
    input  wire logic                  emulation_mode,
    input  wire logic                  debug_rom_mode,
    input  wire logic                  wait_mode,
    input  wire logic                  cpu_valid,
    input  wire logic                  cpu_word,
    input  wire logic [15:0]           cpu_addr,
    output mmd_pkg::mmd_decode_type    decode,
    output logic                       cpu_ready,
    input  wire logic [4:0]            port_k_in,
    output logic      [4:0]            port_k_out,
    output logic      [4:0]            port_k_oe
);

    function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                                 input logic [15:0] mask);
        hit = (a & mask) == (base & mask);
    endfunction

    mmd_pkg::mmd_map_type map_q;
    mmd_pkg::mmd_map_type eff_q;
    logic [2:0]  lock_q;
    logic [2:0]  page_index_q;
    logic        test_window_enable_q;
    logic [4:0]  pk_data_q;
    logic [4:0]  pk_dir_q;
    logic        second_q;

    wire        special    = ~mode_select_special_n;
    wire        wr         = psel & penable & pwrite;
    wire [7:0]  idx        = 8'(paddr >> 2);
    wire        aligned    = paddr[1:0] == 2'b00;
    wire        sel_ram    = aligned && idx == mmd_pkg::RAM_POS_IDX;
    wire        sel_reg    = aligned && idx == mmd_pkg::REG_POS_IDX;
    wire        sel_ee     = aligned && idx == mmd_pkg::EE_POS_IDX;
    wire        sel_misc   = aligned && idx == mmd_pkg::MISC_IDX;
    wire        sel_page   = aligned && idx == mmd_pkg::PAGE_IDX;
    wire        sel_pkd    = aligned && idx == mmd_pkg::PORTK_DAT_IDX;
    wire        sel_pkr    = aligned && idx == mmd_pkg::PORTK_DIR_IDX;
    wire        mapped     = sel_ram | sel_reg | sel_ee | sel_misc | sel_page | sel_pkd | sel_pkr;
    wire [7:0]  wbyte      = pwdata[7:0];

    wire [2:0]  pos_ok     = special ? 3'b111 : ~lock_q;

    wire [7:0]  ram_pos_d  = {wbyte[7:mmd_pkg::RAM_POS_LSB], 5'h00};
    wire [4:0]  reg_fld_d  = pos_ok[1] ? wbyte[7:mmd_pkg::REG_POS_LSB]
                                       : map_q.reg_pos[7:mmd_pkg::REG_POS_LSB];
    wire        msw_d      = special ? map_q.reg_pos[mmd_pkg::MSW_BIT]
                                     : wbyte[mmd_pkg::MSW_BIT];
    wire [3:0]  ee_fld_d   = pos_ok[2] ? wbyte[7:mmd_pkg::EE_POS_LSB]
                                       : map_q.ee_pos[7:mmd_pkg::EE_POS_LSB];

    // Mapping registers; enable bit and stop bit follow their own write rules.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            map_q  <= '{mmd_pkg::RAM_POS_RST, mmd_pkg::REG_POS_RST, mmd_pkg::EE_POS_RST};
            lock_q <= 3'b000;
        end else if (wr) begin
            if (sel_ram && pos_ok[0]) begin
                map_q.ram_pos <= ram_pos_d;
            end
            if (sel_reg) begin
                map_q.reg_pos <= {reg_fld_d, 2'b00, msw_d};
            end
            if (sel_ee) begin
                map_q.ee_pos <= {ee_fld_d, 3'b000, wbyte[mmd_pkg::EE_EN_BIT]};
            end
            if (!special) begin
                lock_q <= lock_q | {sel_ee, sel_reg, sel_ram};
            end
        end
    end

    // decode uses a one-cycle delayed copy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eff_q <= '{mmd_pkg::RAM_POS_RST, mmd_pkg::REG_POS_RST, mmd_pkg::EE_POS_RST};
        end else begin
            eff_q <= map_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            page_index_q         <= 3'h0;
            test_window_enable_q <= 1'b0;
            pk_data_q            <= 5'h00;
            pk_dir_q             <= 5'h00;
        end else if (wr) begin
            if (sel_page) begin
                page_index_q <= wbyte[2:0];
            end
            if (sel_misc) begin
                test_window_enable_q <= wbyte[mmd_pkg::TEST_BIT];
            end
            if (sel_pkd) begin
                pk_data_q <= wbyte[4:0];
            end
            if (sel_pkr) begin
                pk_dir_q <= wbyte[4:0];
            end
        end
    end

    // enable reads as one in single-chip
    wire        ee_en_rd   = map_q.ee_pos[mmd_pkg::EE_EN_BIT] | single_chip;
    wire [7:0]  ee_rd      = {map_q.ee_pos[7:1], ee_en_rd};
    wire [7:0]  rd_byte    = sel_ram  ? map_q.ram_pos :
                             sel_reg  ? map_q.reg_pos :
                             sel_ee   ? ee_rd :
                             sel_misc ? {7'h00, test_window_enable_q} :
                             sel_page ? {5'h00, page_index_q} :
                             sel_pkd  ? {3'h0, port_k_in} :
                             sel_pkr  ? {3'h0, pk_dir_q} : 8'h00;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = {24'h000000, rd_byte};

    // Decode from the effective map.
    // register block at 2K boundary
    wire [15:0] reg_base   = {eff_q.reg_pos[7:mmd_pkg::REG_POS_LSB], 11'h000};
    wire [15:0] ram_base   = {eff_q.ram_pos[7:mmd_pkg::RAM_POS_LSB], 13'h0000};
    wire [15:0] ee_base    = {eff_q.ee_pos[7:mmd_pkg::EE_POS_LSB], 12'h000}
                             | mmd_pkg::EE_UPPER_HALF;
    wire        ee_on      = eff_q.ee_pos[mmd_pkg::EE_EN_BIT] | single_chip;
    wire        stop_map   = wait_mode & eff_q.reg_pos[mmd_pkg::MSW_BIT];

    wire        hit_dbg    = debug_rom_mode & hit(cpu_addr, mmd_pkg::DBG_BASE, mmd_pkg::DBG_MASK);
    wire        hit_reg    = hit(cpu_addr, reg_base, mmd_pkg::REG_MASK);
    wire [15:0] reg_ofs    = cpu_addr & ~mmd_pkg::REG_MASK;
    wire        hit_freg   = hit_reg & hit(reg_ofs, mmd_pkg::FREG_BASE, mmd_pkg::FREG_MASK);
    wire        hit_ram    = hit(cpu_addr, ram_base, mmd_pkg::RAM_MASK);
    wire        hit_ee     = ee_on & hit(cpu_addr, ee_base, mmd_pkg::EE_MASK);
    wire        test_win   = special & test_window_enable_q;
    wire        hit_w32    = test_win & hit(cpu_addr, mmd_pkg::WIN_BASE, mmd_pkg::W32_MASK);
    wire        hit_w16    = ~test_win & hit(cpu_addr, mmd_pkg::WIN_BASE, mmd_pkg::W16_MASK);
    // fixed pages of the top array
    wire        hit_fix6   = hit(cpu_addr, mmd_pkg::FIX6_BASE, mmd_pkg::W16_MASK);
    wire        hit_fix7   = ~test_win & hit(cpu_addr, mmd_pkg::FIX7_BASE, mmd_pkg::W16_MASK);
    wire        hit_flash  = hit_w32 | hit_w16 | hit_fix6 | hit_fix7;

    wire [2:0]  page_sel   = hit_fix6 ? mmd_pkg::PAGE_FIX6 :
                             hit_fix7 ? mmd_pkg::PAGE_FIX7 : page_index_q;
    wire [16:0] flash_ofs  = hit_w32 ? {page_index_q[2:1], cpu_addr[14:0]}
                                     : {page_sel, cpu_addr[13:0]};

    mmd_pkg::mmd_target_type tgt;
    assign tgt = (!cpu_valid || stop_map) ? mmd_pkg::MMD_NONE :
                 hit_dbg   ? mmd_pkg::MMD_DEBUG :
                 hit_freg  ? mmd_pkg::MMD_FLASH_REG :
                 hit_reg   ? mmd_pkg::MMD_REGS :
                 hit_ram   ? mmd_pkg::MMD_RAM :
                 hit_ee    ? mmd_pkg::MMD_EEPROM :
                 hit_flash ? mmd_pkg::MMD_FLASH : mmd_pkg::MMD_EXTERNAL;

    wire [1:0]  arr_sel    = (tgt == mmd_pkg::MMD_FLASH) ? flash_ofs[16:15] : page_index_q[2:1];
    wire [16:0] ofs        = (tgt == mmd_pkg::MMD_FLASH) ? flash_ofs : {1'b0, cpu_addr};
    wire        win_acc    = (tgt == mmd_pkg::MMD_FLASH) & (hit_w16 | hit_w32);

    assign decode = '{tgt, arr_sel, ofs, win_acc};

    wire        split      = cpu_word && (tgt == mmd_pkg::MMD_RAM)
                             && ((cpu_addr & mmd_pkg::RAM_OFS_MASK) == mmd_pkg::RAM_HALF_LAST);
    assign cpu_ready = ~split | second_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            second_q <= 1'b0;
        end else begin
            second_q <= split & ~second_q;
        end
    end

    // The chip select is low only while the program window is being accessed.
    // emulation pins or general I/O
    wire        ecs_n      = ~win_acc;
    wire [4:0]  emu_mask   = emulation_mode ? 5'b10111 : 5'b00000;
    wire [4:0]  emu_val    = {ecs_n, 1'b0, page_index_q};
    assign port_k_out = (emu_val & emu_mask) | (pk_data_q & ~emu_mask);
    assign port_k_oe  = emu_mask | pk_dir_q;

    // Assertions.
    a_lock_holds_ram: assert property (@(posedge clock) disable iff (rst)
        (!special && lock_q[0]) |=> $stable(map_q.ram_pos))
        else $error("locked ram position changed");
    a_lock_first_wr: assert property (@(posedge clock) disable iff (rst)
        (wr && sel_reg && !special) |=> lock_q[1])
        else $error("register position lock not set");
    a_decode_lag: assert property (@(posedge clock) disable iff (rst)
        $changed(map_q) |-> ##1 (eff_q == $past(map_q)))
        else $error("decode copy not updated in time");
    a_reg_wins: assert property (@(posedge clock) disable iff (rst)
        (cpu_valid && !stop_map && !hit_dbg && hit_reg && hit_ram)
        |-> (tgt inside {mmd_pkg::MMD_REGS, mmd_pkg::MMD_FLASH_REG}))
        else $error("ram won over register block");
    a_debug_wins: assert property (@(posedge clock) disable iff (rst)
        (cpu_valid && !stop_map && hit_dbg) |-> tgt == mmd_pkg::MMD_DEBUG)
        else $error("debug rom not selected");
    a_stop_wait: assert property (@(posedge clock) disable iff (rst)
        (special && wr && sel_reg) |=> $stable(map_q.reg_pos[mmd_pkg::MSW_BIT]))
        else $error("stop bit written in special mode");
    a_ee_forced: assert property (@(posedge clock) disable iff (rst)
        single_chip |-> (ee_rd[mmd_pkg::EE_EN_BIT] && ee_on))
        else $error("eeprom enable not forced");
    a_split_two: assert property (@(posedge clock) disable iff (rst)
        (split && !second_q) |-> !cpu_ready ##1 cpu_ready)
        else $error("straddling access not two cycles");
    a_test_only_sp: assert property (@(posedge clock) disable iff (rst)
        hit_w32 |-> (special && test_window_enable_q))
        else $error("test window outside special mode");
    a_pix_drive: assert property (@(posedge clock) disable iff (rst)
        emulation_mode |-> (port_k_out[2:0] == page_index_q && port_k_oe[2:0] == 3'b111))
        else $error("page index pins not driven");
    c_reloc_ram: cover property (@(posedge clock) disable iff (rst)
        wr && sel_ram && !special && !lock_q[0]);
    c_overlap: cover property (@(posedge clock) disable iff (rst)
        cpu_valid && hit_reg && hit_ee);
    c_test_win: cover property (@(posedge clock) disable iff (rst)
        tgt == mmd_pkg::MMD_FLASH && hit_w32);
    c_split: cover property (@(posedge clock) disable iff (rst) split);

endmodule // mmd_decoder
`default_nettype wire

// File: mmd_cpu_model.sv
// CPU-side address master model that presents addresses to the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module mmd_cpu_model (
    input  wire logic                    clock,
    input  wire logic                    cpu_ready,
    input  wire mmd_pkg::mmd_decode_type decode,
    output logic                         cpu_valid,
    output logic                         cpu_word,
    output logic [15:0]                  cpu_addr
);
    initial begin
        cpu_valid = 1'b0;
        cpu_word  = 1'b0;
        cpu_addr  = 16'h0000;
    end

    // One access; n returns the cycles spent until the decoder accepted it.
    task automatic access(input logic [15:0] a, input logic w,
                          output mmd_pkg::mmd_decode_type d, output int n);
        n = 0;
        // idle cycle first: any mapping write before this sees a no-op slot.
        @(posedge clock);
        cpu_valid <= 1'b1;
        cpu_word  <= w;
        cpu_addr  <= a;
        // address held: a straddling word stays up until ready is seen.
        do begin
            @(negedge clock);
            d = decode;
            n++;
            @(posedge clock);
        end while (cpu_ready !== 1'b1 && n < 8);
        cpu_valid <= 1'b0;
        // A released bus must not keep showing the old address.
        cpu_addr  <= ~a;
    endtask
endmodule // mmd_cpu_model
`default_nettype wire

// File: tb_memory_map_decoder.sv
// Self-checking testbench for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_decoder;
    logic                    clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic                    smn, sc, emu, dbg, wt, err;
    logic                    cpu_valid, cpu_word, cpu_ready;
    logic [15:0]             cpu_addr;
    logic [4:0]              pk_in, pk_out, pk_oe;
    mmd_pkg::mmd_decode_type decode, d;
    int                      errors, total_checks, n;

    mmd_decoder #(.ADDR_W(8)) dut_u (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_select_special_n(smn), .single_chip(sc),
        .emulation_mode(emu), .debug_rom_mode(dbg), .wait_mode(wt), .cpu_valid(cpu_valid),
        .cpu_word(cpu_word), .cpu_addr(cpu_addr), .decode(decode), .cpu_ready(cpu_ready),
        .port_k_in(pk_in), .port_k_out(pk_out), .port_k_oe(pk_oe));
    mmd_cpu_model cpu_u (.clock(clock), .cpu_ready(cpu_ready), .decode(decode),
        .cpu_valid(cpu_valid), .cpu_word(cpu_word), .cpu_addr(cpu_addr));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic test_done;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Zero-wait slave still gets the full setup/access handshake.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b1, idx, {24'h0, v});
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b0, idx, 32'h0);
        cmp(rd, {24'h0, v});
    endtask

    // Offset is compared only for flash targets, where paging shapes it.
    task automatic at(input logic [15:0] a, input mmd_pkg::mmd_target_type t,
                      input logic [16:0] ofs);
        cpu_u.access(a, 1'b0, d, n);
        if (n >= 8) begin
            errors++;
            test_done();
        end
        cmp({29'h0, d.target}, {29'h0, t});
        if (t == mmd_pkg::MMD_FLASH)
            cmp({15'h0, d.offset}, {15'h0, ofs});
    endtask

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; smn = 1'b1; sc = 1'b0; emu = 1'b0; dbg = 1'b0; wt = 1'b0;
        pk_in = 5'h15; errors = 0; total_checks = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rdchk(mmd_pkg::RAM_POS_IDX, 8'h20);
        rdchk(mmd_pkg::REG_POS_IDX, 8'h00);
        rdchk(mmd_pkg::EE_POS_IDX, 8'h01);
        at(16'h0000, mmd_pkg::MMD_REGS, 17'h0);
        at(16'h0400, mmd_pkg::MMD_EXTERNAL, 17'h0);
        at(16'h2000, mmd_pkg::MMD_RAM, 17'h0);
        at(16'h0fff, mmd_pkg::MMD_EEPROM, 17'h0);
        at(16'h4000, mmd_pkg::MMD_FLASH, 17'h18000);
        at(16'hc123, mmd_pkg::MMD_FLASH, 17'h1c123);
        wr(mmd_pkg::PORTK_DIR_IDX, 8'h1f);
        wr(mmd_pkg::PORTK_DAT_IDX, 8'h0a);
        @(negedge clock);
        cmp({22'h0, pk_oe, pk_out}, {22'h0, 5'h1f, 5'h0a});
        rdchk(mmd_pkg::PORTK_DAT_IDX, {3'h0, pk_in});
        emu <= 1'b1;
        for (int p = 0; p < 8; p++) begin
            wr(mmd_pkg::PAGE_IDX, {5'h0, p[2:0]});
            at({13'h1000, p[2:0]}, mmd_pkg::MMD_FLASH, {p[2:0], 11'h0, p[2:0]});
            cmp({31'h0, d.in_window}, 32'h1);
            cpu_u.access(16'h00f4, 1'b0, d, n);
            cmp({27'h0, d.target, d.array_sel}, {27'h0, 3'd3, p[2:1]});
            // The chip select must stay high while the flash register window is accessed.
            cmp({22'h0, pk_oe[4], pk_out[4], pk_oe[3], pk_out[3], pk_oe[2:0], pk_out[2:0]},
                {22'h0, 2'b11, 5'h1f, p[2:0]});
        end
        emu <= 1'b0;
        wr(mmd_pkg::MISC_IDX, 8'h01);
        at(16'hc010, mmd_pkg::MMD_FLASH, 17'h1c010);
        wr(mmd_pkg::REG_POS_IDX, 8'h08);
        wr(mmd_pkg::RAM_POS_IDX, 8'h00);
        at(16'h0800, mmd_pkg::MMD_REGS, 17'h0);
        at(16'h0c00, mmd_pkg::MMD_RAM, 17'h0);
        at(16'h0400, mmd_pkg::MMD_RAM, 17'h0);
        cpu_u.access(16'h0fff, 1'b1, d, n);
        cmp(n, 2);
        cpu_u.access(16'h0ffe, 1'b1, d, n);
        cmp(n, 1);
        wr(mmd_pkg::RAM_POS_IDX, 8'h40);
        rdchk(mmd_pkg::RAM_POS_IDX, 8'h00);
        wr(mmd_pkg::REG_POS_IDX, 8'h11);
        rdchk(mmd_pkg::REG_POS_IDX, 8'h09);
        wt <= 1'b1;
        at(16'h0800, mmd_pkg::MMD_NONE, 17'h0);
        wt <= 1'b0;
        wr(mmd_pkg::EE_POS_IDX, 8'h30);
        at(16'h3800, mmd_pkg::MMD_EXTERNAL, 17'h0);
        wr(mmd_pkg::EE_POS_IDX, 8'h51);
        rdchk(mmd_pkg::EE_POS_IDX, 8'h31);
        at(16'h3800, mmd_pkg::MMD_EEPROM, 17'h0);
        smn <= 1'b0;
        wr(mmd_pkg::REG_POS_IDX, 8'h00);
        rdchk(mmd_pkg::REG_POS_IDX, 8'h01);
        wr(mmd_pkg::EE_POS_IDX, 8'h50);
        rdchk(mmd_pkg::EE_POS_IDX, 8'h50);
        at(16'h5800, mmd_pkg::MMD_FLASH, 17'h19800);
        sc <= 1'b1;
        at(16'h5800, mmd_pkg::MMD_EEPROM, 17'h0);
        sc <= 1'b0;
        wr(mmd_pkg::PAGE_IDX, 8'h03);
        at(16'h8010, mmd_pkg::MMD_FLASH, 17'h08010);
        at(16'hc010, mmd_pkg::MMD_FLASH, 17'h0c010);
        dbg <= 1'b1;
        at(16'hff10, mmd_pkg::MMD_DEBUG, 17'h0);
        dbg <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        cmp({rd[30:0], err}, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        smn <= 1'b1;
        wr(mmd_pkg::RAM_POS_IDX, 8'h40);
        at(16'h4000, mmd_pkg::MMD_RAM, 17'h0);
        rdchk(mmd_pkg::RAM_POS_IDX, 8'h40);
        test_done();
    end
endmodule // tb_memory_map_decoder
`default_nettype wire
